// ==== src/sff_consts.svh ====
// constants of the serial flash front end: opcodes, status bit positions, timing
// assumes a 40 MHz system clock sampling the serial pins
`ifndef SFF_CONSTS_SVH
`define SFF_CONSTS_SVH
`define SFF_OP_WREN 8'h06
`define SFF_OP_WRDI 8'h04
`define SFF_OP_RDSR1 8'h05
`define SFF_OP_RDSR2 8'h35
`define SFF_OP_WRSR 8'h01
`define SFF_OP_PP 8'h02
`define SFF_OP_QPP 8'h32
`define SFF_OP_SE 8'h20
`define SFF_OP_BE32 8'h52
`define SFF_OP_BE64 8'hD8
`define SFF_OP_CE 8'hC7
`define SFF_OP_SECE 8'h44
`define SFF_OP_SECP 8'h42
`define SFF_OP_PD 8'hB9
`define SFF_OP_RPD 8'hAB
`define SFF_OP_SUSP 8'h75
`define SFF_OP_RESM 8'h7A
`define SFF_OP_FRD 8'h3B
`define SFF_OP_FRDIO 8'hBB
`define SFF_OP_FRQ 8'h6B
`define SFF_OP_FRQIO 8'hEB
`define SFF_BIT_BUSY 0
`define SFF_BIT_LATCH 1
`define SFF_BIT_BP_LO 2
`define SFF_BIT_TB 5
`define SFF_BIT_SEC 6
`define SFF_BIT_STATUS_LOCK_LOW 7
`define SFF_BIT_STATUS_LOCK_HIGH 8
`define SFF_BIT_QE 9
`define SFF_BIT_CMP 14
`define SFF_BIT_SUS 15
`define SFF_STATUS_RESET 16'h0000
`define SFF_CLK_NS 25
`define SFF_PUW_US 5000
`define SFF_PUW_CYCLES ((`SFF_PUW_US * 1000) / `SFF_CLK_NS)
`define SFF_OP_TIME_CYCLES 16'h0040
`endif

// ==== src/sff_pkg.sv ====
// types of the serial flash front end
// assumes sff_consts.svh holds the numbers
package sff_pkg;
    typedef enum logic [2:0] {SFF_OPCODE, SFF_ADDR, SFF_DATA_IN, SFF_DATA_OUT, SFF_IGNORE} sff_phase_e;
    typedef enum logic [1:0] {SFF_LANES1, SFF_LANES2, SFF_LANES4} sff_width_e;
endpackage

// ==== src/sff_buffer.sv ====
// two-entry byte buffer with valid and ready on both sides
// assumes one clock domain; the drain side may stall at will
`timescale 1ns/1ps
`default_nettype none
module sff_buffer (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [7:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    logic [7:0] store [0:1];
    logic rd_idx;
    logic wr_idx;
    logic [1:0] count;
    logic push;
    logic pop;

    assign push = in_valid_in && (count != 2'h2);
    assign pop = out_ready_in && (count != 2'h0);
    assign in_ready_out = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out = store[rd_idx];

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            store[wr_idx] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rd_idx <= 1'b0;
            wr_idx <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // sff_buffer
`default_nettype wire

// ==== src/sff_front_end.sv ====
// serial flash front end: instruction shifter, pause, write latch, status protection
// assumes all serial pins are asynchronous to sys_clk_in and far slower than it
`timescale 1ns/1ps
`default_nettype none
`include "sff_consts.svh"
module sff_front_end #(
    parameter int PUW_CYCLES = `SFF_PUW_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic supply_good_in,
    input wire logic serial_clk_in,
    input wire logic select_n_in,
    input wire logic lane_zero_in,
    output logic lane_zero_out,
    output logic lane_zero_oe_n_out,
    input wire logic lane_one_in,
    output logic lane_one_out,
    output logic lane_one_oe_n_out,
    input wire logic lane_two_in,
    output logic lane_two_out,
    output logic lane_two_oe_n_out,
    input wire logic lane_three_in,
    output logic lane_three_out,
    output logic lane_three_oe_n_out,
    output logic [7:0] wr_data_out,
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output logic [7:0] flash_status_low_out,
    output logic paused_out
);
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] d0_s;
    logic [1:0] d1_s;
    logic [1:0] d2_s;
    logic [1:0] d3_s;
    logic sclk_q;
    logic cs_q;
    logic [15:0] status;
    logic [7:0] opcode;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [2:0] bit_cnt;
    logic [4:0] addr_cnt;
    logic byte_done;
    sff_pkg::sff_phase_e phase;
    sff_pkg::sff_width_e width;
    logic paused;
    logic power_down;
    logic [22:0] puw_cnt;
    logic [15:0] op_cnt;
    logic [15:0] status_new;
    logic status_half;
    logic pending_write;
    logic status_pending;
    logic drive;
    logic [3:0] out_bits;
    logic [7:0] buf_data;
    logic buf_valid;
    logic buf_in_ready;
    logic rise;
    logic fall;
    logic sel;
    logic pause_n;
    logic quad_mode;
    logic active;

    function automatic logic is_write_op(input logic [7:0] op);
        return op == `SFF_OP_PP || op == `SFF_OP_QPP || op == `SFF_OP_SE || op == `SFF_OP_BE32 ||
            op == `SFF_OP_BE64 || op == `SFF_OP_CE || op == `SFF_OP_WRSR || op == `SFF_OP_SECE ||
            op == `SFF_OP_SECP;
    endfunction

    // lanes a read opcode moves its data on
    function automatic sff_pkg::sff_width_e read_width(input logic [7:0] op, input logic qe);
        if (op == `SFF_OP_FRD || op == `SFF_OP_FRDIO) begin
            return sff_pkg::SFF_LANES2;
        end else if ((op == `SFF_OP_FRQ || op == `SFF_OP_FRQIO) && qe) begin
            return sff_pkg::SFF_LANES4;
        end
        return sff_pkg::SFF_LANES1;
    endfunction

    always_ff @(posedge sys_clk_in) begin
        sclk_s <= {sclk_s[0], serial_clk_in};
        cs_s <= {cs_s[0], select_n_in};
        d0_s <= {d0_s[0], lane_zero_in};
        d1_s <= {d1_s[0], lane_one_in};
        d2_s <= {d2_s[0], lane_two_in};
        d3_s <= {d3_s[0], lane_three_in};
        sclk_q <= sclk_s[1];
        cs_q <= cs_s[1];
    end

    // mode 0 and mode 3 differ only in idle level, so edges alone drive the shifter
    assign rise = sclk_s[1] && !sclk_q;
    assign fall = !sclk_s[1] && sclk_q;
    assign sel = !cs_s[1];
    assign quad_mode = status[`SFF_BIT_QE];
    assign pause_n = d3_s[1];
    assign active = sel && supply_good_in && !paused;
    assign byte_done = rise && active && bit_cnt == 3'h0;

    // pause: pin effect only selected and with four lanes off
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !sel || quad_mode || !supply_good_in) begin
            paused <= 1'b0;
        end else if (!paused && !pause_n && (!sclk_s[1] || fall)) begin
            paused <= 1'b1;
        end else if (paused && pause_n && (!sclk_s[1] || fall)) begin
            paused <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !supply_good_in) begin
            puw_cnt <= 23'h0;
        end else if (puw_cnt != PUW_CYCLES[22:0]) begin
            puw_cnt <= puw_cnt + 23'h1;
        end
    end

    // instruction shifter; select high drops any partial instruction
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !sel || !supply_good_in) begin
            phase <= sff_pkg::SFF_OPCODE;
            width <= sff_pkg::SFF_LANES1;
            bit_cnt <= 3'h7;
            addr_cnt <= 5'h0;
            opcode <= 8'h00;
            shift_in <= 8'h00;
            status_half <= 1'b0;
        end else if (rise && active) begin
            case (width)
                sff_pkg::SFF_LANES4: begin
                    shift_in <= {shift_in[3:0], d3_s[1], d2_s[1], d1_s[1], d0_s[1]};
                    bit_cnt <= bit_cnt - 3'h4;
                end
                sff_pkg::SFF_LANES2: begin
                    shift_in <= {shift_in[5:0], d1_s[1], d0_s[1]};
                    bit_cnt <= bit_cnt - 3'h2;
                end
                default: begin
                    shift_in <= {shift_in[6:0], d0_s[1]};
                    bit_cnt <= bit_cnt - 3'h1;
                end
            endcase
            if (bit_cnt == 3'h0 || (width == sff_pkg::SFF_LANES2 && bit_cnt == 3'h1) ||
                (width == sff_pkg::SFF_LANES4 && bit_cnt == 3'h3)) begin
                bit_cnt <= 3'h7;
                case (phase)
                    sff_pkg::SFF_OPCODE: begin
                        opcode <= {shift_in[6:0], d0_s[1]};
                        if ({shift_in[6:0], d0_s[1]} == `SFF_OP_WRSR ||
                            {shift_in[6:0], d0_s[1]} == `SFF_OP_RDSR1 ||
                            {shift_in[6:0], d0_s[1]} == `SFF_OP_RDSR2) begin
                            phase <= ({shift_in[6:0], d0_s[1]} == `SFF_OP_WRSR) ?
                                sff_pkg::SFF_DATA_IN : sff_pkg::SFF_DATA_OUT;
                        end else if (is_write_op({shift_in[6:0], d0_s[1]}) ||
                            read_width({shift_in[6:0], d0_s[1]}, quad_mode) != sff_pkg::SFF_LANES1) begin
                            phase <= sff_pkg::SFF_ADDR;
                            width <= ({shift_in[6:0], d0_s[1]} == `SFF_OP_FRDIO) ? sff_pkg::SFF_LANES2 :
                                ({shift_in[6:0], d0_s[1]} == `SFF_OP_FRQIO && quad_mode) ?
                                sff_pkg::SFF_LANES4 : sff_pkg::SFF_LANES1;
                        end else begin
                            phase <= sff_pkg::SFF_IGNORE;
                        end
                    end
                    sff_pkg::SFF_ADDR: begin
                        addr_cnt <= addr_cnt + 5'h1;
                        if (addr_cnt == 5'h2) begin
                            phase <= (opcode == `SFF_OP_PP || opcode == `SFF_OP_QPP || opcode == `SFF_OP_SECP) ?
                                sff_pkg::SFF_DATA_IN : sff_pkg::SFF_DATA_OUT;
                            width <= read_width(opcode, quad_mode);
                        end
                    end
                    sff_pkg::SFF_DATA_IN: begin
                        status_half <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // the two-entry buffer absorbs a host that outruns a stalled sink
    sff_buffer u_buffer (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_data_in(buf_data),
        .in_valid_in(buf_valid),
        .in_ready_out(buf_in_ready),
        .out_data_out(wr_data_out),
        .out_valid_out(wr_valid_out),
        .out_ready_in(wr_ready_in)
    );

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            buf_valid <= 1'b0;
            buf_data <= 8'h00;
        end else begin
            buf_valid <= byte_done && phase == sff_pkg::SFF_DATA_IN && opcode != `SFF_OP_WRSR &&
                pending_write && buf_in_ready;
            buf_data <= {shift_in[6:0], d0_s[1]};
        end
    end

    // execution at the rising edge of select
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !supply_good_in) begin
            status <= `SFF_STATUS_RESET;
            power_down <= 1'b0;
            op_cnt <= 16'h0;
            pending_write <= 1'b0;
            status_pending <= 1'b0;
            status_new <= 16'h0;
        end else begin
            if (status[`SFF_BIT_BUSY]) begin
                op_cnt <= op_cnt - 16'h1;
                if (op_cnt == 16'h1) begin
                    status[`SFF_BIT_BUSY] <= 1'b0;
                    status[`SFF_BIT_LATCH] <= 1'b0;
                    if (status_pending) begin
                        status[15:2] <= {status[15], status_new[14:2]};
                        status_pending <= 1'b0;
                    end
                end
            end
            if (phase == sff_pkg::SFF_OPCODE && byte_done) begin
                pending_write <= is_write_op({shift_in[6:0], d0_s[1]}) && status[`SFF_BIT_LATCH];
            end
            if (byte_done && opcode == `SFF_OP_WRSR && phase == sff_pkg::SFF_DATA_IN) begin
                if (status_half) begin
                    status_new[15:8] <= {shift_in[6:0], d0_s[1]};
                end else begin
                    status_new[7:0] <= {shift_in[6:0], d0_s[1]};
                    status_new[15:8] <= status[15:8];
                end
            end
            // select just released: opcode and phase still hold the frame, the shifter clears them this edge
            if (cs_s[1] && !cs_q && phase != sff_pkg::SFF_ADDR && !paused) begin
                if (power_down) begin
                    if (opcode == `SFF_OP_RPD) begin
                        power_down <= 1'b0;
                    end
                end else if (status[`SFF_BIT_BUSY]) begin
                    if (opcode == `SFF_OP_SUSP) begin
                        status[`SFF_BIT_SUS] <= 1'b1;
                    end
                end else if (opcode == `SFF_OP_RESM) begin
                    status[`SFF_BIT_SUS] <= 1'b0;
                end else if (opcode == `SFF_OP_PD) begin
                    power_down <= 1'b1;
                end else if (opcode == `SFF_OP_WRDI) begin
                    status[`SFF_BIT_LATCH] <= 1'b0;
                end else if (puw_cnt == PUW_CYCLES[22:0]) begin
                    if (opcode == `SFF_OP_WREN) begin
                        status[`SFF_BIT_LATCH] <= 1'b1;
                    end else if (is_write_op(opcode) && status[`SFF_BIT_LATCH]) begin
                        if (opcode != `SFF_OP_WRSR || (!status[`SFF_BIT_STATUS_LOCK_HIGH] &&
                            !(status[`SFF_BIT_STATUS_LOCK_LOW] && !d2_s[1] && !quad_mode))) begin
                            status[`SFF_BIT_BUSY] <= 1'b1;
                            op_cnt <= `SFF_OP_TIME_CYCLES;
                            status_pending <= (opcode == `SFF_OP_WRSR);
                        end
                    end
                end
            end
        end
    end

    // output shifter clears while deselected and otherwise changes on falling clock edges only
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !sel) begin
            shift_out <= 8'h00;
            drive <= 1'b0;
        end else if (fall && active && !power_down && phase == sff_pkg::SFF_DATA_OUT) begin
            drive <= 1'b1;
            if (bit_cnt == 3'h7) begin
                shift_out <= (opcode == `SFF_OP_RDSR2) ? status[15:8] : status[7:0];
            end else begin
                shift_out <= (width == sff_pkg::SFF_LANES4) ? {shift_out[3:0], 4'h0} :
                    (width == sff_pkg::SFF_LANES2) ? {shift_out[5:0], 2'h0} : {shift_out[6:0], 1'b0};
            end
        end
    end

    always_comb begin
        out_bits = 4'h0;
        case (width)
            sff_pkg::SFF_LANES4: out_bits = shift_out[7:4];
            sff_pkg::SFF_LANES2: out_bits = {2'h0, shift_out[7:6]};
            default: out_bits = {2'h0, shift_out[7], 1'b0};
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        lane_zero_out <= out_bits[0];
        lane_one_out <= out_bits[1];
        lane_two_out <= out_bits[2];
        lane_three_out <= out_bits[3];
        lane_zero_oe_n_out <= !(drive && active && width != sff_pkg::SFF_LANES1);
        lane_one_oe_n_out <= !(drive && active);
        lane_two_oe_n_out <= !(drive && active && width == sff_pkg::SFF_LANES4);
        lane_three_oe_n_out <= !(drive && active && width == sff_pkg::SFF_LANES4);
        flash_status_low_out <= status[7:0];
        paused_out <= paused;
    end
endmodule // sff_front_end
`default_nettype wire

// ==== verification/sff_chk.sv ====
// checker of the flash front end ports
// assumes it is bound into sff_front_end, single clock domain
`timescale 1ns/1ps
`default_nettype none
module sff_chk (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic supply_good_in,
    input wire logic serial_clk_in,
    input wire logic select_n_in,
    input wire logic lane_three_in,
    input wire logic lane_one_out,
    input wire logic lane_zero_oe_n_out,
    input wire logic lane_one_oe_n_out,
    input wire logic [7:0] wr_data_out,
    input wire logic wr_valid_out,
    input wire logic wr_ready_in,
    input wire logic [7:0] flash_status_low_out,
    input wire logic paused_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic [7:0] since_fall;
    logic [7:0] busy_len;
    logic clk_q;
    // saturates so a long idle never wraps into a false match
    always_ff @(posedge sys_clk_in) begin
        clk_q <= serial_clk_in;
        if (rst_in) since_fall <= 8'hFF;
        else if (clk_q && !serial_clk_in) since_fall <= 8'h00;
        else if (since_fall != 8'hFF) since_fall <= since_fall + 8'h01;
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !flash_status_low_out[0]) busy_len <= 8'h00;
        else busy_len <= busy_len + 8'h01;
    end
    sequence s_idle8; select_n_in [*8]; endsequence
    sequence s_held(v); !select_n_in && !serial_clk_in && lane_three_in == v; endsequence
    property p_float_idle; s_idle8 |-> lane_one_oe_n_out && !paused_out; endproperty
    a_float_idle: assert property (p_float_idle) else $error("drive while deselected");
    property p_pause_float; paused_out [*2] |-> lane_zero_oe_n_out && lane_one_oe_n_out; endproperty
    a_pause_float: assert property (p_pause_float) else $error("drive while paused");
    property p_out_edge; !lane_one_oe_n_out && $changed(lane_one_out) |-> since_fall <= 8'h08; endproperty
    a_out_edge: assert property (p_out_edge) else $error("output moved off falling edge");
    property p_no_supply; !supply_good_in [*4] |-> lane_one_oe_n_out && !flash_status_low_out[1]; endproperty
    a_no_supply: assert property (p_no_supply) else $error("active without supply");
    property p_busy_len; $fell(flash_status_low_out[0]) |-> busy_len >= 8'h38 && busy_len <= 8'h48; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_busy_end; $rose(flash_status_low_out[0]) |-> ##[1:80] !flash_status_low_out[0]; endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy never ends");
    property p_latch_idle; $rose(flash_status_low_out[1]) |-> !flash_status_low_out[0]; endproperty
    a_latch_idle: assert property (p_latch_idle) else $error("latch set while busy");
    property p_done_clear; $fell(flash_status_low_out[0]) |-> !flash_status_low_out[1]; endproperty
    a_done_clear: assert property (p_done_clear) else $error("latch kept after write");
    property p_buf_hold; wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_data_out); endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("stalled byte lost");
    property p_pause_in; $fell(lane_three_in) ##0 s_held(1'b0) [*7] |-> paused_out; endproperty
    a_pause_in: assert property (p_pause_in) else $error("pause not entered");
    property p_pause_out; $rose(lane_three_in) ##0 s_held(1'b1) [*7] |-> !paused_out; endproperty
    a_pause_out: assert property (p_pause_out) else $error("pause not left");
endmodule // sff_chk
bind sff_front_end sff_chk sff_chk_i (.*);
`default_nettype wire

// ==== verification/sff_host.sv ====
// host model: serial clock, select and lane drive for the front end
// assumes the front end lanes are split into value and active-low enable
`timescale 1ns/1ps
`default_nettype none
module sff_host (
    input wire logic [3:0] dev_out_in,
    input wire logic [3:0] dev_oe_n_in,
    output logic serial_clk_out,
    output logic select_n_out,
    output logic [3:0] pin_out
);
    logic cpol = 1'b0;
    logic d0 = 1'b0;
    logic wp_n = 1'b1;
    logic pause_n = 1'b1;
    logic fill = 1'b0;
    // released lane one toggles so a stale value never reads as data; lanes zero, two and three fall back to d0, wp_n and pause_n
    always #25 fill = ~fill;
    assign pin_out = {dev_oe_n_in[3] ? pause_n : dev_out_in[3], dev_oe_n_in[2] ? wp_n : dev_out_in[2],
        dev_oe_n_in[1] ? fill : dev_out_in[1], dev_oe_n_in[0] ? d0 : dev_out_in[0]};
    initial begin
        serial_clk_out = 1'b0;
        select_n_out = 1'b1;
    end
    task automatic sel(input logic on);
        #37;
        serial_clk_out = cpol;
        #100;
        select_n_out = !on;
        #100;
        if (!on) d0 = ~d0;
        #300;
    endtask
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_clk_out = 1'b0;
            d0 = tx[i];
            #100;
            serial_clk_out = 1'b1;
            #100;
            // late in the high phase: the answer trails the fall by a few system cycles
            rx[i] = pin_out[1];
        end
    endtask
    // one byte over two or four lanes, highest lane carries the highest bit
    task automatic lanes(input int w, output logic [7:0] v);
        v = 8'h00;
        repeat (8 / w) begin
            serial_clk_out = 1'b0;
            #100;
            serial_clk_out = 1'b1;
            #100;
            v = (w == 4) ? {v[3:0], pin_out} : {v[5:0], pin_out[1:0]};
        end
    endtask
    task automatic wiggle(input int n);
        serial_clk_out = 1'b0;
        #100;
        repeat (n) begin
            serial_clk_out = 1'b1;
            d0 = ~d0;
            #100;
            serial_clk_out = 1'b0;
            #100;
        end
    endtask
endmodule // sff_host
`default_nettype wire

// ==== verification/tb_top.sv ====
// top bench: host model, reference status model and the bound checker
// assumes sff_host on the serial side, 40 MHz system clock
`timescale 1ns/1ps
`default_nettype none
`include "sff_consts.svh"
module tb_top;
    // short power-up delay keeps the run brief; one frame still fits inside it
    localparam int PUW = 400;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic supply_good_in = 1'b0;
    logic wr_ready_in = 1'b1;
    logic serial_clk;
    logic select_n;
    logic [3:0] pin;
    logic [3:0] dout;
    logic [3:0] doe_n;
    logic [7:0] wr_data;
    logic [7:0] stat;
    logic wr_valid;
    logic paused;
    logic [31:0] rx;
    logic [7:0] q[$];
    int fails = 0;
    int comparisons = 0;
    int m_stat = 0;
    bit m_pd = 1'b0;
    bit m_ok = 1'b0;
    always #12.5 sys_clk_in = ~sys_clk_in;
    sff_host sff_host_i (.dev_out_in(dout), .dev_oe_n_in(doe_n), .serial_clk_out(serial_clk),
        .select_n_out(select_n), .pin_out(pin));
    sff_front_end #(.PUW_CYCLES(PUW)) sff_front_end_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .supply_good_in(supply_good_in), .serial_clk_in(serial_clk), .select_n_in(select_n),
        .lane_zero_in(pin[0]), .lane_zero_out(dout[0]), .lane_zero_oe_n_out(doe_n[0]),
        .lane_one_in(pin[1]), .lane_one_out(dout[1]), .lane_one_oe_n_out(doe_n[1]),
        .lane_two_in(pin[2]), .lane_two_out(dout[2]), .lane_two_oe_n_out(doe_n[2]),
        .lane_three_in(pin[3]), .lane_three_out(dout[3]), .lane_three_oe_n_out(doe_n[3]),
        .wr_data_out(wr_data), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready_in),
        .flash_status_low_out(stat), .paused_out(paused));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask
    task automatic model(input logic [7:0] op, input logic [7:0] b1);
        if (!supply_good_in) return;
        if (m_pd) begin
            if (op == `SFF_OP_RPD) m_pd = 1'b0;
            return;
        end
        case (op)
            `SFF_OP_WREN: if (m_ok) m_stat = m_stat | 2;
            `SFF_OP_WRDI, `SFF_OP_PP: m_stat = m_stat & ~2;
            `SFF_OP_PD: m_pd = 1'b1;
            `SFF_OP_WRSR: if ((m_stat & 2) && !((m_stat & 8'h80) && !sff_host_i.wp_n)) m_stat = b1 & 8'hFC;
            default: ;
        endcase
    endtask
    task automatic cmd(input logic [7:0] op, input int nb, input logic [31:0] d);
        sff_host_i.sel(1'b1);
        sff_host_i.xfer(8, {24'h0, op}, rx);
        if (nb > 0) sff_host_i.xfer(nb * 8, d, rx);
        sff_host_i.sel(1'b0);
        model(op, d[15:8]);
    endtask
    // waits out busy, then reads the status at the port and, when ser is set, over the lanes
    task automatic settle(input string what, input bit ser);
        int n;
        n = 0;
        tick(1);
        while (stat[0] !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        if (n >= 200) begin
            fails++;
            report_and_stop();
        end
        if (ser) begin
            sff_host_i.sel(1'b1);
            sff_host_i.xfer(16, {16'h0, `SFF_OP_RDSR1, 8'h00}, rx);
            sff_host_i.sel(1'b0);
            cmp({what, " lanes"}, m_stat[7:0], rx[7:0]);
        end
        cmp(what, m_stat[7:0], stat);
        $display("test %s finished", what);
        tick(1);
    endtask
    initial begin
        void'($urandom(32'hA8FD4E38));
        tick(10);
        rst_in = 1'b0;
        tick(4);
        cmd(`SFF_OP_WREN, 0, 32'h0);
        settle("no supply", 1'b0);
        supply_good_in = 1'b1;
        tick(4);
        cmd(`SFF_OP_WREN, 0, 32'h0);
        settle("early write", 1'b1);
        tick(PUW);
        m_ok = 1'b1;
        for (int m = 0; m < 2; m++) begin
            sff_host_i.cpol = m[0];
            cmd(`SFF_OP_WREN, 0, 32'h0);
            settle("latch set", 1'b1);
            cmd(`SFF_OP_WRDI, 0, 32'h0);
            settle("latch clear", 1'b1);
        end
        sff_host_i.cpol = 1'b0;
        sff_host_i.sel(1'b1);
        sff_host_i.xfer(4, 32'h0, rx);
        sff_host_i.sel(1'b0);
        settle("abort", 1'b1);
        cmd(`SFF_OP_WRSR, 2, {16'h0, 8'h9C, 8'h00});
        settle("no latch", 1'b1);
        cmd(`SFF_OP_WREN, 0, 32'h0);
        tick(1);
        wr_ready_in = 1'b0;
        q = {8'($urandom), 8'($urandom)};
        sff_host_i.sel(1'b1);
        sff_host_i.xfer(32, {`SFF_OP_PP, 24'($urandom)}, rx);
        sff_host_i.xfer(16, {16'h0, q[0], q[1]}, rx);
        sff_host_i.sel(1'b0);
        model(`SFF_OP_PP, 8'h00);
        tick(1);
        for (int k = 0; k < 2; k++) begin
            cmp("wr valid", 8'h01, {7'h0, wr_valid});
            cmp("wr data", q[k], wr_data);
            wr_ready_in = 1'b1;
            tick(1);
            wr_ready_in = 1'b0;
            tick(1);
        end
        cmp("buffer empty", 8'h00, {7'h0, wr_valid});
        wr_ready_in = 1'b1;
        settle("program", 1'b1);
        cmd(`SFF_OP_WREN, 0, 32'h0);
        cmd(`SFF_OP_WRSR, 2, {16'h0, 8'h9C, 8'h00});
        settle("protect bits", 1'b1);
        sff_host_i.wp_n = 1'b0;
        cmd(`SFF_OP_WREN, 0, 32'h0);
        cmd(`SFF_OP_WRSR, 2, 32'h0);
        cmd(`SFF_OP_WRDI, 0, 32'h0);
        settle("pin lock", 1'b1);
        sff_host_i.wp_n = 1'b1;
        cmd(`SFF_OP_WREN, 0, 32'h0);
        cmd(`SFF_OP_WRSR, 2, 32'h0);
        settle("pin free", 1'b1);
        cmd(`SFF_OP_PD, 0, 32'h0);
        cmd(`SFF_OP_WREN, 0, 32'h0);
        settle("sleep", 1'b0);
        cmd(`SFF_OP_RPD, 0, 32'h0);
        cmd(`SFF_OP_WREN, 0, 32'h0);
        settle("wake", 1'b1);
        cmd(`SFF_OP_WRDI, 0, 32'h0);
        sff_host_i.sel(1'b1);
        sff_host_i.xfer(4, 32'h0, rx);
        sff_host_i.wiggle(0);
        sff_host_i.pause_n = 1'b0;
        tick(8);
        cmp("pause entry", 8'h01, {7'h0, paused});
        sff_host_i.wiggle(3);
        sff_host_i.pause_n = 1'b1;
        tick(8);
        cmp("pause exit", 8'h00, {7'h0, paused});
        sff_host_i.xfer(4, 32'h6, rx);
        sff_host_i.sel(1'b0);
        model(`SFF_OP_WREN, 8'h00);
        settle("pause resume", 1'b1);
        cmd(`SFF_OP_WREN, 0, 32'h0);
        cmd(`SFF_OP_WRSR, 2, 32'h1C02);
        settle("four lanes", 1'b1);
        // status comes back over the wide lanes; lanes two and three carry data in the quad read only
        for (int w = 2; w <= 4; w += 2) begin
            sff_host_i.sel(1'b1);
            sff_host_i.xfer(32, {(w == 2) ? `SFF_OP_FRD : `SFF_OP_FRQ, 24'($urandom)}, rx);
            sff_host_i.lanes(w, rx[7:0]);
            sff_host_i.sel(1'b0);
            cmp((w == 2) ? "dual read" : "quad read", m_stat[7:0], rx[7:0]);
        end
        $display("test wide reads finished");
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
